// ### verilog/cpu_regs_cfg.svh
// Named constants of the programmer-visible CPU register set.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CPU_REGS_CFG_SVH
`define CPU_REGS_CFG_SVH

// ****************************************************************
// Reset values
// ****************************************************************
`define SP_RESET        16'h00FF
`define INDEX_HI_RESET  8'h00
`define VEC_ADDR_HIGH   16'hFFFE
`define VEC_ADDR_LOW    16'hFFFF

// ****************************************************************
// Condition flag bit positions
// ****************************************************************
`define FLAG_V          7
`define FLAG_ONE6       6
`define FLAG_ONE5       5
`define FLAG_H          4
`define FLAG_I          3
`define FLAG_N          2
`define FLAG_Z          1
`define FLAG_C          0

// ****************************************************************
// Arithmetic constants
// ****************************************************************
`define BCD_LOW_FIX     8'h06
`define BCD_HIGH_FIX    8'h60
`define BCD_DIGIT_MAX   4'h9
`define BCD_BYTE_MAX    8'h99
`define SIGN_MIN        8'h80
`define SIGN_MAX        8'h7F

`endif

// ### verilog/cpu_regs_pkg.sv
// Types shared by the register set and its flag unit.
// Assumes cpu_regs_cfg.svh is on the include path.
`include "cpu_regs_cfg.svh"

package cpu_regs_pkg;

    // ****************************************************************
    // Register-set operations
    // ****************************************************************
    typedef enum logic [4:0] {
        OP_LOAD_A    = 5'h00,
        OP_STORE_A   = 5'h01,
        OP_LOAD_X    = 5'h02,
        OP_LOAD_HX   = 5'h03,
        OP_ADD       = 5'h04,
        OP_ADC       = 5'h05,
        OP_SUB       = 5'h06,
        OP_SBC       = 5'h07,
        OP_BCD       = 5'h08,
        OP_TAX       = 5'h09,
        OP_TXA       = 5'h0A,
        OP_CLR_X     = 5'h0B,
        OP_INC_X     = 5'h0C,
        OP_DEC_X     = 5'h0D,
        OP_COM_X     = 5'h0E,
        OP_NEG_X     = 5'h0F,
        OP_LSL_X     = 5'h10,
        OP_LSR_X     = 5'h11,
        OP_ROL_X     = 5'h12,
        OP_ROR_X     = 5'h13,
        OP_ADJ       = 5'h14,
        OP_SLR       = 5'h15,
        OP_CLM       = 5'h16,
        OP_SEI       = 5'h17,
        OP_TAP       = 5'h18,
        OP_TPA       = 5'h19,
        OP_FETCH     = 5'h1A,
        OP_JUMP      = 5'h1B,
        OP_BRANCH    = 5'h1C,
        OP_IRQ_ENTRY = 5'h1D,
        OP_PUSH      = 5'h1E,
        OP_PULL      = 5'h1F
    } op_e;

    typedef enum logic [2:0] {
        COND_ALWAYS        = 3'h0,
        COND_EQUAL         = 3'h1,
        COND_NOT_EQUAL     = 3'h2,
        COND_CARRY         = 3'h3,
        COND_SIGNED_GT     = 3'h4,
        COND_SIGNED_GE     = 3'h5,
        COND_SIGNED_LE     = 3'h6,
        COND_SIGNED_LT     = 3'h7
    } cond_e;

    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  idx_hi;
        logic [7:0]  idx_lo;
        logic [15:0] sp;
        logic [15:0] pc;
        logic        v;
        logic        h;
        logic        i;
        logic        n;
        logic        z;
        logic        c;
        logic        accept;
        logic        taken;
    } regs_s;

endpackage

// ### verilog/alu_flag_unit.sv
// Combinational 8-bit data path for the accumulator and index low byte.
// Assumes the caller applies result and flags on the same clock edge.
`timescale 1ns/10ps
`include "cpu_regs_cfg.svh"

module alu_flag_unit
(
    input  wire cpu_regs_pkg::op_e op,
    input  wire logic [7:0]        acc,
    input  wire logic [7:0]        x,
    input  wire logic [7:0]        operand,
    input  wire logic              carry_in,
    input  wire logic              half_in,
    output logic [7:0]             result,
    output logic                   write_acc,
    output logic                   write_x,
    output logic                   upd_v,
    output logic                   upd_h,
    output logic                   upd_c,
    output logic                   upd_nz,
    output logic                   flag_v,
    output logic                   flag_h,
    output logic                   flag_c
);

    logic [8:0] sum9;
    logic [4:0] lo5;
    logic       cin;
    logic       fix_low;
    logic       fix_high;

    always_comb
    begin
        sum9      = 9'h000;
        lo5       = 5'h00;
        cin       = 1'b0;
        fix_low   = 1'b0;
        fix_high  = 1'b0;
        result    = acc;
        write_acc = 1'b0;
        write_x   = 1'b0;
        upd_v     = 1'b0;
        upd_h     = 1'b0;
        upd_c     = 1'b0;
        upd_nz    = 1'b0;
        flag_v    = 1'b0;
        flag_h    = 1'b0;
        flag_c    = 1'b0;
        case (op)
            cpu_regs_pkg::OP_LOAD_A, cpu_regs_pkg::OP_STORE_A, cpu_regs_pkg::OP_LOAD_X:
            begin
                result    = (op == cpu_regs_pkg::OP_STORE_A) ? acc : operand;
                write_acc = (op == cpu_regs_pkg::OP_LOAD_A);
                write_x   = (op == cpu_regs_pkg::OP_LOAD_X);
                upd_v     = 1'b1;
                upd_nz    = 1'b1;
            end
            cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_ADC:
            begin
                cin       = (op == cpu_regs_pkg::OP_ADC) & carry_in;
                sum9      = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
                lo5       = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
                result    = sum9[7:0];
                write_acc = 1'b1;
                flag_c    = sum9[8];
                flag_h    = lo5[4];
                flag_v    = (acc[7] == operand[7]) && (result[7] != acc[7]);
                {upd_v, upd_h, upd_c, upd_nz} = 4'hF;
            end
            cpu_regs_pkg::OP_SUB, cpu_regs_pkg::OP_SBC:
            begin
                cin       = (op == cpu_regs_pkg::OP_SBC) & carry_in;
                sum9      = {1'b0, acc} - {1'b0, operand} - {8'h00, cin};
                result    = sum9[7:0];
                write_acc = 1'b1;
                flag_c    = sum9[8];
                flag_v    = (acc[7] != operand[7]) && (result[7] != acc[7]);
                {upd_v, upd_c, upd_nz} = 3'h7;
            end
            cpu_regs_pkg::OP_BCD:
            begin
                // Correction picked from the flags left by the preceding add and from the accumulator digits
                fix_low   = half_in || (acc[3:0] > `BCD_DIGIT_MAX);
                fix_high  = carry_in || (acc > `BCD_BYTE_MAX);
                result    = acc + (fix_low ? `BCD_LOW_FIX : 8'h00)
                                + (fix_high ? `BCD_HIGH_FIX : 8'h00);
                write_acc = 1'b1;
                flag_c    = fix_high;
                {upd_c, upd_nz} = 2'h3;
            end
            cpu_regs_pkg::OP_TAX:
            begin
                result  = acc;
                write_x = 1'b1;
            end
            cpu_regs_pkg::OP_TXA:
            begin
                result    = x;
                write_acc = 1'b1;
            end
            cpu_regs_pkg::OP_CLR_X, cpu_regs_pkg::OP_INC_X, cpu_regs_pkg::OP_DEC_X,
            cpu_regs_pkg::OP_COM_X, cpu_regs_pkg::OP_NEG_X:
            begin
                write_x = 1'b1;
                upd_v   = 1'b1;
                upd_nz  = 1'b1;
                case (op)
                    cpu_regs_pkg::OP_CLR_X: result = 8'h00;
                    cpu_regs_pkg::OP_INC_X: result = x + 8'h01;
                    cpu_regs_pkg::OP_DEC_X: result = x - 8'h01;
                    cpu_regs_pkg::OP_COM_X: result = ~x;
                    default:                result = 8'h00 - x;
                endcase
                flag_v = ((op == cpu_regs_pkg::OP_INC_X) && (result == `SIGN_MIN))
                      || ((op == cpu_regs_pkg::OP_DEC_X) && (result == `SIGN_MAX))
                      || ((op == cpu_regs_pkg::OP_NEG_X) && (result == `SIGN_MIN));
                upd_c  = (op == cpu_regs_pkg::OP_COM_X) || (op == cpu_regs_pkg::OP_NEG_X);
                flag_c = (op == cpu_regs_pkg::OP_COM_X) || (result != 8'h00);
            end
            cpu_regs_pkg::OP_LSL_X, cpu_regs_pkg::OP_LSR_X,
            cpu_regs_pkg::OP_ROL_X, cpu_regs_pkg::OP_ROR_X:
            begin
                write_x = 1'b1;
                {upd_v, upd_c, upd_nz} = 3'h7;
                case (op)
                    cpu_regs_pkg::OP_LSL_X: result = {x[6:0], 1'b0};
                    cpu_regs_pkg::OP_ROL_X: result = {x[6:0], carry_in};
                    cpu_regs_pkg::OP_LSR_X: result = {1'b0, x[7:1]};
                    default:                result = {carry_in, x[7:1]};
                endcase
                flag_c = ((op == cpu_regs_pkg::OP_LSL_X) || (op == cpu_regs_pkg::OP_ROL_X))
                         ? x[7] : x[0];
                // Shift overflow is N xor C, which is sign change for the left shifts
                flag_v = result[7] ^ flag_c;
            end
            default:
            begin
                result = acc;
            end
        endcase
    end

endmodule // alu_flag_unit

// ### verilog/cpu_register_set.sv
// Programmer-visible CPU register set with condition flags and
// interrupt-mask timing. Assumes a sequencer on the same clock issues
// one operation per cycle and presents the reset vector bytes in reset.
`timescale 1ns/10ps
`include "cpu_regs_cfg.svh"

module cpu_register_set
(
    input  wire logic              CLOCK,
    input  wire logic              RST_N,
    input  wire logic              OP_VALID,
    input  wire cpu_regs_pkg::op_e OP,
    input  wire cpu_regs_pkg::cond_e COND,
    input  wire logic [15:0]       DATA_IN,
    input  wire logic              BOUNDARY,
    input  wire logic              IRQ_PENDING,
    input  wire logic [7:0]        VECTOR_BYTE_HIGH_ADDR,
    input  wire logic [7:0]        VECTOR_BYTE_LOW_ADDR,
    output logic [7:0]             ACCUMULATOR,
    output logic [15:0]            INDEX_PAIR,
    output logic [15:0]            STACK_POINTER,
    output logic [15:0]            PROGRAM_COUNTER,
    output logic [7:0]             CONDITION_FLAGS,
    output logic                   IRQ_ACCEPT,
    output logic                   BRANCH_TAKEN
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] sign_extend(input logic [7:0] value);
        sign_extend = {{8{value[7]}}, value};
    endfunction

    function automatic logic [7:0] pack_flags(input cpu_regs_pkg::regs_s r);
        logic [7:0] f;
        f             = 8'h00;
        f[`FLAG_V]    = r.v;
        f[`FLAG_ONE6] = 1'b1;
        f[`FLAG_ONE5] = 1'b1;
        f[`FLAG_H]    = r.h;
        f[`FLAG_I]    = r.i;
        f[`FLAG_N]    = r.n;
        f[`FLAG_Z]    = r.z;
        f[`FLAG_C]    = r.c;
        pack_flags    = f;
    endfunction

    function automatic logic cond_true(input cpu_regs_pkg::cond_e cond,
                                       input cpu_regs_pkg::regs_s r);
        case (cond)
            cpu_regs_pkg::COND_ALWAYS:    cond_true = 1'b1;
            cpu_regs_pkg::COND_EQUAL:     cond_true = r.z;
            cpu_regs_pkg::COND_NOT_EQUAL: cond_true = !r.z;
            cpu_regs_pkg::COND_CARRY:     cond_true = r.c;
            cpu_regs_pkg::COND_SIGNED_GT: cond_true = !(r.z | (r.n ^ r.v));
            cpu_regs_pkg::COND_SIGNED_GE: cond_true = !(r.n ^ r.v);
            cpu_regs_pkg::COND_SIGNED_LE: cond_true = r.z | (r.n ^ r.v);
            default:                      cond_true = r.n ^ r.v;
        endcase
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    cpu_regs_pkg::regs_s cur;
    cpu_regs_pkg::regs_s next_cur;

    logic [7:0] alu_result;
    logic       alu_write_acc;
    logic       alu_write_x;
    logic       alu_upd_v;
    logic       alu_upd_h;
    logic       alu_upd_c;
    logic       alu_upd_nz;
    logic       alu_v;
    logic       alu_h;
    logic       alu_c;
    logic       mask_just_cleared;

    alu_flag_unit u_alu
    (
        .op        (OP),
        .acc       (cur.acc),
        .x         (cur.idx_lo),
        .operand   (DATA_IN[7:0]),
        .carry_in  (cur.c),
        .half_in   (cur.h),
        .result    (alu_result),
        .write_acc (alu_write_acc),
        .write_x   (alu_write_x),
        .upd_v     (alu_upd_v),
        .upd_h     (alu_upd_h),
        .upd_c     (alu_upd_c),
        .upd_nz    (alu_upd_nz),
        .flag_v    (alu_v),
        .flag_h    (alu_h),
        .flag_c    (alu_c)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        next_cur          = cur;
        next_cur.accept   = 1'b0;
        next_cur.taken    = 1'b0;
        mask_just_cleared = 1'b0;

        if (!RST_N)
        begin
            // Accumulator and index low byte deliberately kept
            next_cur.idx_hi = `INDEX_HI_RESET;
            next_cur.sp     = `SP_RESET;
            next_cur.pc     = {VECTOR_BYTE_HIGH_ADDR, VECTOR_BYTE_LOW_ADDR};
            // Mask held set so nothing is taken before software is ready
            next_cur.i      = 1'b1;
        end
        else if (OP_VALID)
        begin
            if (alu_write_acc)
                next_cur.acc = alu_result;
            if (alu_write_x)
                next_cur.idx_lo = alu_result;
            if (alu_upd_v)
                next_cur.v = alu_v;
            if (alu_upd_h)
                next_cur.h = alu_h;
            if (alu_upd_c)
                next_cur.c = alu_c;
            if (alu_upd_nz)
            begin
                next_cur.n = alu_result[7];
                next_cur.z = (alu_result == 8'h00);
            end

            case (OP)
                cpu_regs_pkg::OP_LOAD_HX:
                begin
                    {next_cur.idx_hi, next_cur.idx_lo} = DATA_IN;
                    next_cur.v = 1'b0;
                    next_cur.n = DATA_IN[15];
                    next_cur.z = (DATA_IN == 16'h0000);
                end
                cpu_regs_pkg::OP_ADJ:
                    next_cur.sp = cur.sp + sign_extend(DATA_IN[7:0]);
                cpu_regs_pkg::OP_SLR:
                    next_cur.sp[7:0] = 8'(`SP_RESET);
                // Push writes at the free slot, then steps down to the next
                cpu_regs_pkg::OP_PUSH:
                    next_cur.sp = cur.sp - 16'h0001;
                cpu_regs_pkg::OP_PULL:
                    next_cur.sp = cur.sp + 16'h0001;
                cpu_regs_pkg::OP_CLM:
                begin
                    next_cur.i        = 1'b0;
                    mask_just_cleared = 1'b1;
                end
                cpu_regs_pkg::OP_SEI:
                    next_cur.i = 1'b1;
                cpu_regs_pkg::OP_TAP:
                begin
                    next_cur.v        = cur.acc[`FLAG_V];
                    next_cur.h        = cur.acc[`FLAG_H];
                    next_cur.i        = cur.acc[`FLAG_I];
                    next_cur.n        = cur.acc[`FLAG_N];
                    next_cur.z        = cur.acc[`FLAG_Z];
                    next_cur.c        = cur.acc[`FLAG_C];
                    mask_just_cleared = 1'b1;
                end
                cpu_regs_pkg::OP_TPA:
                    next_cur.acc = pack_flags(cur);
                cpu_regs_pkg::OP_FETCH:
                    next_cur.pc = cur.pc + 16'h0001;
                cpu_regs_pkg::OP_JUMP:
                    next_cur.pc = DATA_IN;
                cpu_regs_pkg::OP_BRANCH:
                begin
                    if (cond_true(COND, cur))
                    begin
                        next_cur.pc    = cur.pc + sign_extend(DATA_IN[7:0]);
                        next_cur.taken = 1'b1;
                    end
                end
                cpu_regs_pkg::OP_IRQ_ENTRY:
                begin
                    // Issued by the sequencer once registers are stacked
                    next_cur.i  = 1'b1;
                    next_cur.pc = DATA_IN;
                end
                default:
                begin
                    next_cur.sp = cur.sp;
                end
            endcase

            // Uses the mask as it stands after this op, so SEI blocks at once
            if (BOUNDARY && IRQ_PENDING && !next_cur.i && !mask_just_cleared)
                next_cur.accept = 1'b1;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        cur <= next_cur;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Flag byte is rebuilt from flops only; bits six and five are constants
    assign ACCUMULATOR     = cur.acc;
    assign INDEX_PAIR      = {cur.idx_hi, cur.idx_lo};
    assign STACK_POINTER   = cur.sp;
    assign PROGRAM_COUNTER = cur.pc;
    assign CONDITION_FLAGS = pack_flags(cur);
    assign IRQ_ACCEPT      = cur.accept;
    assign BRANCH_TAKEN    = cur.taken;

endmodule // cpu_register_set

// ### bench/cpu_register_set_asserts.sv
// Port-level assertions for the CPU register set.
// Assumes it is bound into cpu_register_set, one clock, synchronous reset.
`timescale 1ns/10ps

module cpu_register_set_asserts
(
    input wire logic                CLOCK,
    input wire logic                RST_N,
    input wire logic                OP_VALID,
    input wire cpu_regs_pkg::op_e   OP,
    input wire cpu_regs_pkg::cond_e COND,
    input wire logic [15:0]         DATA_IN,
    input wire logic                BOUNDARY,
    input wire logic                IRQ_PENDING,
    input wire logic [7:0]          VECTOR_BYTE_HIGH_ADDR,
    input wire logic [7:0]          VECTOR_BYTE_LOW_ADDR,
    input wire logic [7:0]          ACCUMULATOR,
    input wire logic [15:0]         INDEX_PAIR,
    input wire logic [15:0]         STACK_POINTER,
    input wire logic [15:0]         PROGRAM_COUNTER,
    input wire logic [7:0]          CONDITION_FLAGS,
    input wire logic                IRQ_ACCEPT,
    input wire logic                BRANCH_TAKEN
);
    // ****
    // Helpers and assertions
    // ****
    logic [15:0] adj_step;
    logic        gate;
    assign adj_step = {{8{DATA_IN[7]}}, DATA_IN[7:0]};
    assign gate = OP_VALID && BOUNDARY && IRQ_PENDING;

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    reset_regs_a:
        assert property ($rose(RST_N) |-> STACK_POINTER == 16'h00FF && INDEX_PAIR[15:8] == 8'h00)
        else $error("stack or index high wrong after reset");
    reset_vec_a:
        assert property ($rose(RST_N) |->
            PROGRAM_COUNTER == {$past(VECTOR_BYTE_HIGH_ADDR), $past(VECTOR_BYTE_LOW_ADDR)})
        else $error("program counter not from vector");
    clm_refuse_a:
        assert property (gate && OP inside {cpu_regs_pkg::OP_CLM, cpu_regs_pkg::OP_TAP}
            |=> !IRQ_ACCEPT)
        else $error("interrupt right after mask clear");
    masked_irq_a:
        assert property (gate && CONDITION_FLAGS[3] && !(OP inside {cpu_regs_pkg::OP_CLM,
            cpu_regs_pkg::OP_TAP, cpu_regs_pkg::OP_PULL}) |=> !IRQ_ACCEPT)
        else $error("masked interrupt accepted");
    open_irq_a:
        assert property (gate && !CONDITION_FLAGS[3] && OP == cpu_regs_pkg::OP_LOAD_A
            |=> IRQ_ACCEPT)
        else $error("open interrupt refused");
    entry_mask_a:
        assert property (OP_VALID && OP == cpu_regs_pkg::OP_IRQ_ENTRY
            |=> CONDITION_FLAGS[3] && PROGRAM_COUNTER == $past(DATA_IN))
        else $error("interrupt entry mask or target wrong");
    ais_add_a:
        assert property (OP_VALID && OP == cpu_regs_pkg::OP_ADJ
            |=> STACK_POINTER == $past(STACK_POINTER) + $past(adj_step))
        else $error("stack adjust sum wrong");
    slr_low_a:
        assert property (OP_VALID && OP == cpu_regs_pkg::OP_SLR
            |=> $stable(STACK_POINTER[15:8]) && STACK_POINTER[7:0] == 8'hFF)
        else $error("stack reinit touched high byte");
endmodule // cpu_register_set_asserts

bind cpu_register_set cpu_register_set_asserts chk
(
    .CLOCK, .RST_N, .OP_VALID, .OP, .COND, .DATA_IN, .BOUNDARY, .IRQ_PENDING,
    .VECTOR_BYTE_HIGH_ADDR, .VECTOR_BYTE_LOW_ADDR, .ACCUMULATOR, .INDEX_PAIR,
    .STACK_POINTER, .PROGRAM_COUNTER, .CONDITION_FLAGS, .IRQ_ACCEPT, .BRANCH_TAKEN
);

// ### bench/cpu_register_set_tb.sv
// Self-checking bench for the CPU register set, queue scoreboard.
// Assumes header, package, design and checker are compiled first.
`timescale 1ns/10ps

module cpu_register_set_tb;
    // ****
    // Signals, scoreboard, drivers
    // ****
    typedef struct {int sel; logic [15:0] msk; logic [15:0] val;} exp_s;
    exp_s                q[$];
    int                  error_cnt = 0;
    int                  n_checks = 0;
    logic                clock, rst_n, op_valid, boundary, irq, irq_acc, taken, c, t;
    cpu_regs_pkg::op_e   op;
    cpu_regs_pkg::cond_e cond;
    logic [15:0]         data, idx, sp, pc, e_sp, e_pc, w;
    logic [7:0]          acc, flags, vhi, vlo, a, x, r;
    logic [7:0]          ta[5] = '{8'h08, 8'h7F, 8'h80, 8'h00, 8'h09};
    logic [7:0]          tb[5] = '{8'h08, 8'h01, 8'h80, 8'h01, 8'h08};
    logic [7:0]          tf[5] = '{8'h10, 8'h94, 8'h83, 8'h05, 8'h10};
    logic [7:0]          sa[3] = '{8'h80, 8'h7F, 8'h7F};
    cpu_regs_pkg::op_e   xo[11] = '{cpu_regs_pkg::OP_CLR_X, cpu_regs_pkg::OP_INC_X,
        cpu_regs_pkg::OP_DEC_X, cpu_regs_pkg::OP_COM_X, cpu_regs_pkg::OP_NEG_X,
        cpu_regs_pkg::OP_TAX, cpu_regs_pkg::OP_LSL_X, cpu_regs_pkg::OP_ROL_X,
        cpu_regs_pkg::OP_LSR_X, cpu_regs_pkg::OP_ROR_X, cpu_regs_pkg::OP_TXA};

    cpu_register_set dut
    (
        .CLOCK(clock), .RST_N(rst_n), .OP_VALID(op_valid), .OP(op), .COND(cond),
        .DATA_IN(data), .BOUNDARY(boundary), .IRQ_PENDING(irq),
        .VECTOR_BYTE_HIGH_ADDR(vhi), .VECTOR_BYTE_LOW_ADDR(vlo), .ACCUMULATOR(acc),
        .INDEX_PAIR(idx), .STACK_POINTER(sp), .PROGRAM_COUNTER(pc),
        .CONDITION_FLAGS(flags), .IRQ_ACCEPT(irq_acc), .BRANCH_TAKEN(taken)
    );

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    function automatic logic [15:0] pick(int s);
        case (s)
            0: return {8'h00, acc};
            1: return idx;
            2: return sp;
            3: return pc;
            4: return {8'h00, flags};
            5: return {15'h0000, irq_acc};
            default: return {15'h0000, taken};
        endcase
    endfunction

    task automatic chk(exp_s e);
        n_checks++;
        if ((pick(e.sel) & e.msk) !== e.val)
        begin
            error_cnt++;
            $display("wrong value at %0t: item %0d is %h not %h", $time, e.sel,
                     pick(e.sel) & e.msk, e.val);
        end
    endtask

    task automatic ex(int s, logic [15:0] m, logic [15:0] v);
        q.push_back('{s, m, v});
    endtask

    // Called just after an edge; returns just after the edge that takes the op
    task automatic run(cpu_regs_pkg::op_e o, logic [15:0] d, logic b = 0, logic p = 0);
        op_valid = 1'b1;
        op = o;
        data = d;
        boundary = b;
        irq = p;
        @(posedge clock);
        #1;
    endtask

    task results;
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Results are one cycle late, so notes queued after an op are due now
    initial
    forever
    begin
        @(posedge clock);
        #2;
        while (q.size() > 0)
            chk(q.pop_front());
    end

    // Tests take about a hundred cycles; 4000 cycles means a hang
    initial
    begin
        #20000;
        error_cnt++;
        results;
    end

    initial
    begin
        void'($urandom(32'h5c6b_d7ba));
        {rst_n, op_valid, boundary, irq} = 4'h0;
        op = cpu_regs_pkg::OP_FETCH;
        cond = cpu_regs_pkg::COND_ALWAYS;
        data = 16'h0000;
        vhi = 8'($urandom);
        vlo = 8'($urandom);
        repeat (3) @(posedge clock);
        #1;
        rst_n = 1'b1;
        ex(2, 16'hFFFF, 16'h00FF);
        ex(1, 16'hFF00, 16'h0000);
        ex(3, 16'hFFFF, {vhi, vlo});
        ex(4, 16'h0068, 16'h0068);
        a = 8'($urandom);
        w = 16'($urandom);
        run(cpu_regs_pkg::OP_LOAD_A, {8'h00, a});
        run(cpu_regs_pkg::OP_LOAD_HX, w);
        ex(1, 16'hFFFF, w);
        ex(4, 16'h0006, {13'h0000, w[15], w == 16'h0000, 1'b0});
        op_valid = 1'b0;
        rst_n = 1'b0;
        @(posedge clock);
        #1;
        rst_n = 1'b1;
        ex(0, 16'h00FF, {8'h00, a});
        ex(1, 16'hFFFF, {8'h00, w[7:0]});
        $display("test reset done");
        for (int i = 0; i < 5; i++)
        begin
            run(cpu_regs_pkg::OP_LOAD_A, {8'h00, ta[i]});
            run(i == 3 ? cpu_regs_pkg::OP_SUB : cpu_regs_pkg::OP_ADD, {8'h00, tb[i]});
            ex(0, 16'h00FF, {8'h00, i == 3 ? ta[i] - tb[i] : ta[i] + tb[i]});
            ex(4, i == 3 ? 16'h0087 : 16'h0097, {8'h00, tf[i]});
        end
        run(cpu_regs_pkg::OP_BCD, 16'h0000);
        ex(0, 16'h00FF, 16'h0017);
        ex(4, 16'h0001, 16'h0000);
        $display("test arithmetic done");
        for (int i = 0; i < 11; i++)
        begin
            x = 8'($urandom);
            run(cpu_regs_pkg::OP_LOAD_X, {8'h00, x});
            run(xo[i], 16'h0000);
            case (i)
                0: r = 8'h00;
                1: r = x + 8'h01;
                2: r = x - 8'h01;
                3: r = ~x;
                4: r = 8'h00 - x;
                5: r = 8'h17;
                6: {c, r} = {x, 1'b0};
                7: {c, r} = {x, c};
                8: {r, c} = {1'b0, x};
                9: {r, c} = {c, x};
                default: r = x;
            endcase
            ex(i == 10 ? 0 : 1, 16'h00FF, {8'h00, r});
            if (i != 5 && i != 10)
                ex(4, i > 5 ? 16'h0007 : 16'h0006, {13'h0000, r[7], r == 8'h00, c & (i > 5)});
        end
        $display("test index low done");
        e_sp = 16'h00FF;
        for (int i = 0; i < 9; i++)
        begin
            x = i < 3 ? sa[i] : 8'($urandom);
            op = i == 3 ? cpu_regs_pkg::OP_SLR : i == 7 ? cpu_regs_pkg::OP_PUSH :
                 i == 8 ? cpu_regs_pkg::OP_PULL : cpu_regs_pkg::OP_ADJ;
            if (i == 3)
                e_sp[7:0] = 8'hFF;
            else
                e_sp = e_sp + (i == 7 ? 16'hFFFF : i == 8 ? 16'h0001 : {{8{x[7]}}, x});
            run(op, {8'h00, x});
            ex(2, 16'hFFFF, e_sp);
        end
        $display("test stack done");
        w = 16'($urandom);
        run(cpu_regs_pkg::OP_JUMP, w);
        run(cpu_regs_pkg::OP_FETCH, 16'h0000);
        e_pc = w + 16'h0001;
        ex(3, 16'hFFFF, e_pc);
        for (int k = 0; k < 32; k++)
        begin
            if (k % 8 == 0)
            begin
                a = 8'($urandom) | 8'h08;
                run(cpu_regs_pkg::OP_LOAD_A, {8'h00, a});
                run(cpu_regs_pkg::OP_TAP, 16'h0000);
            end
            x = 8'($urandom);
            cond = cpu_regs_pkg::cond_e'(k[2:0]);
            case (k % 8)
                0: t = 1'b1;
                1: t = a[1];
                2: t = !a[1];
                3: t = a[0];
                4: t = !(a[1] | (a[2] ^ a[7]));
                5: t = !(a[2] ^ a[7]);
                6: t = a[1] | (a[2] ^ a[7]);
                default: t = a[2] ^ a[7];
            endcase
            run(cpu_regs_pkg::OP_BRANCH, {8'h00, x});
            if (t)
                e_pc = e_pc + {{8{x[7]}}, x};
            ex(6, 16'h0001, {15'h0000, t});
            ex(3, 16'hFFFF, e_pc);
        end
        $display("test branch done");
        run(cpu_regs_pkg::OP_SEI, 16'h0000, 1'b1, 1'b1);
        ex(5, 16'h0001, 16'h0000);
        run(cpu_regs_pkg::OP_CLM, 16'h0000, 1'b1, 1'b1);
        ex(5, 16'h0001, 16'h0000);
        run(cpu_regs_pkg::OP_LOAD_A, 16'h0000, 1'b1, 1'b1);
        ex(5, 16'h0001, 16'h0001);
        w = 16'($urandom);
        run(cpu_regs_pkg::OP_IRQ_ENTRY, w);
        ex(4, 16'h0008, 16'h0008);
        ex(3, 16'hFFFF, w);
        run(cpu_regs_pkg::OP_TAP, 16'h0000, 1'b1, 1'b1);
        ex(5, 16'h0001, 16'h0000);
        op_valid = 1'b0;
        @(posedge clock);
        #1;
        ex(5, 16'h0001, 16'h0000);
        $display("test interrupt done");
        @(posedge clock);
        #3;
        results;
    end
endmodule // cpu_register_set_tb
